//--- hdl/rpsp_pkg.sv
// Shared constants and types of the regulator pin, status and sync block
`default_nettype none
package rpsp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IGNORE = 8'h08;
  localparam logic [7:0] OFS_RATE   = 8'h0C;
  localparam logic [7:0] OFS_RATEQ  = 8'h10;
  localparam logic [7:0] OFS_TRANS  = 8'h14;
  localparam logic [7:0] OFS_BOOTA  = 8'h18;
  localparam logic [7:0] OFS_BOOTB  = 8'h1C;
  localparam logic [7:0] OFS_VOUTA  = 8'h20;
  localparam logic [7:0] OFS_VOUTB  = 8'h24;
  localparam logic [7:0] OFS_SYNC   = 8'h28;
  localparam logic [7:0] OFS_PHMAP  = 8'h2C;
  localparam logic [7:0] OFS_TEMP   = 8'h30;
  localparam logic [7:0] OFS_TRIM   = 8'h34;
  // Control fields
  localparam int CTL_IMMOFF = 2;
  localparam int CTL_BOTH   = 3;
  localparam int CTL_OC     = 4;
  localparam int CTL_OT     = 5;
  localparam logic [1:0] FN_ENB  = 2'h0;
  localparam logic [1:0] FN_RST  = 2'h1;
  localparam logic [1:0] FN_SYNC = 2'h2;
  // Sync configuration fields
  localparam int SY_EN = 0;
  localparam int SY_MASTER = 1;
  localparam int SY_DIV = 2;
  localparam int SY_GAIN = 14;
  // Reset values
  localparam logic [22:0] BOOT_RST = 23'h0F4240;
  localparam logic [15:0] TRANS_RST = 16'h03E8;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int US_CYC = CLK_MHZ;
  localparam int START_WAIT_US = 750;
  // Stage line thresholds in mV
  localparam logic [11:0] UVLO_MV = 12'h0C8;
  localparam logic [11:0] FAULT_MV = 12'h9C4;
  localparam logic [11:0] TEMP_OFS_MV = 12'h258;
  localparam int TEMP_SHIFT = 3;
  // Supported ramp rates in uV/us
  localparam int N_RATES = 32;
  localparam logic [15:0] RATES [N_RATES] = '{
    16'd93, 16'd97, 16'd101, 16'd105, 16'd111, 16'd117, 16'd124,
    16'd131, 16'd140, 16'd151, 16'd1163, 16'd175, 16'd192, 16'd213,
    16'd238, 16'd265, 16'd313, 16'd625, 16'd938, 16'd1250, 16'd1563,
    16'd1875, 16'd2188, 16'd2500, 16'd5000, 16'd10000, 16'd15000,
    16'd20000, 16'd25000, 16'd30000, 16'd35000, 16'd40000};
  typedef enum logic [4:0] {
    CH_OFF  = 5'h01,
    CH_WAIT = 5'h02,
    CH_RAMP = 5'h04,
    CH_REG  = 5'h08,
    CH_SOFT = 5'h10
  } rpsp_ch_e;
endpackage
`default_nettype wire

//--- hdl/rpsp_core.sv
// Pin-level control, status, sync and PWM sequencing of a dual regulator
// Contract
// - Ramp rates snap to the nearest entry of the supported rate table.
// - Power good releases only once the reference reaches boot voltage.
// - Power good pulls low whenever a channel stops converting.
// - Warnings and ignored faults leave power good alone.
// - Fault output asserts only for non-ignored critical faults, selectable.
// - Fault sources: overvoltages, stage, input/output overcurrent, temperature.
// - Shared pin defaults to enable B; otherwise enable A drives both.
// - Voltage reset low ramps both targets to boot at transition rate.
// - Target writes are discarded while voltage reset stays low.
// - Voltage reset touches targets only, never operating state.
// - With sync on, order 0 PWM locks to sync via on-time trim.
// - Load transients drop lock; relock is slow afterwards.
// - Sync config: enable, direction, division, phase shift, gain; the code stores a phase shift but never applies it.
// - PWM pins are three-state: high, low or undriven.
// - Starting a phase goes from undriven straight to high.
// - Stopping a phase goes from low to undriven.
// - Stage line low means stages cannot accept PWM.
// - Stage line high means a power-stage fault.
// - Temperature is line voltage minus 600 mV over 8 mV per degree.
// - Immediate-off disable undrives all channel PWM at once.
// - After enable wait 750 us plus turn-on delay before ramping.
//
// Our own choices: the APB slave port and the placing of the registers.
`default_nettype none
module rpsp_core #(
  parameter int STARTUP_WAIT_US = rpsp_pkg::START_WAIT_US
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Enable pins and shared pin
  input  wire logic        chanAEnableIn,
  input  wire logic        chanBEnableIn,
  input  wire logic        sharedPinIn,
  output var  logic        sharedPinOut,
  output var  logic        sharedPinOe,
  // Fault events per channel and load transient flag
  input  wire logic [5:0]  faultEvtA,
  input  wire logic [5:0]  faultEvtB,
  input  wire logic        loadTransient,
  // Digitised stage temperature/fault lines in mV
  input  wire logic [11:0] chanATempSenseMv,
  input  wire logic [11:0] chanBTempSenseMv,
  // Modulator side
  input  wire logic [11:0] phaseActive,
  input  wire logic [11:0] pwmCmd,
  output var  logic [11:0] pwmOut,
  output var  logic [11:0] pwmOe,
  // Open-drain status pins
  input  wire logic        chanAPowerGoodIn,
  output var  logic        chanAPowerGoodOut,
  output var  logic        chanAPowerGoodOe,
  input  wire logic        chanBPowerGoodIn,
  output var  logic        chanBPowerGoodOut,
  output var  logic        chanBPowerGoodOe,
  input  wire logic        criticalFaultNIn,
  output var  logic        criticalFaultNOut,
  output var  logic        criticalFaultNOe
);
  import rpsp_pkg::*;

  localparam logic [6:0] US_LAST = 7'(US_CYC - 1);
  localparam logic [15:0] WAIT_US = 16'(STARTUP_WAIT_US);

  typedef struct packed {
    rpsp_ch_e [1:0]    cs;
    logic [1:0][22:0]  refV;
    logic [1:0][22:0]  boot;
    logic [1:0][22:0]  vout;
    logic [1:0][16:0]  dly;
    logic [6:0]        us;
    logic [1:0]        fl;
    logic [1:0]        cl;
    logic [5:0]        ctrl;
    logic [6:0]        ign;
    logic [31:0]       rate;
    logic [31:0]       rq;
    logic [31:0]       trans;
    logic [17:0]       sync;
    logic [11:0]       map;
    logic [1:0][7:0]   temp;
    logic [1:0]        uv;
    logic [1:0]        sf;
    logic [7:0]        trim;
    logic              lock;
    logic              dir;
    logic [3:0]        dcnt;
    logic              s1;
    logic              s2;
    logic              s3;
    logic              vr;
    logic [11:0]       pon;
    logic [11:0]       pwm;
    logic [1:0]        pgOe;
    logic              critOe;
    logic              shOut;
    logic              shOe;
    logic [31:0]       rdata;
    logic              rdy;
    logic              err;
  } rpsp_state_s;

  rpsp_state_s r;
  rpsp_state_s next_r;

  // Value of the nearest supported rate
  function automatic logic [15:0] nearRate(input logic [15:0] want);
    logic [15:0] best;
    logic [16:0] bd;
    logic [16:0] d;
    best = RATES[0];
    bd = 17'h1FFFF;
    for (int k = 0; k < N_RATES; k++) begin
      d = (want > RATES[k]) ? 17'(want - RATES[k]) : 17'(RATES[k] - want);
      if (d < bd) begin
        bd = d;
        best = RATES[k];
      end
    end
    return best;
  endfunction

  // One step of a reference toward its goal
  function automatic logic [22:0] stepRef(input logic [22:0] cur,
                                          input logic [22:0] goal,
                                          input logic [15:0] rate);
    if (cur < goal)
      return (goal - cur > 23'(rate)) ? cur + 23'(rate) : goal;
    else
      return (cur - goal > 23'(rate)) ? cur - 23'(rate) : goal;
  endfunction

  logic [1:0]       en;
  logic [1:0]       shut;
  logic [1:0]       conv;
  logic [1:0]       kill;
  logic [1:0][6:0]  raw;
  logic [1:0][6:0]  crit;
  logic [1:0][11:0] tmv;
  logic             tick;
  logic             wr;
  logic             syncEdge;
  logic             chB;
  logic             phEn;
  logic [22:0]      goal;
  logic [15:0]      rt;

  always_comb begin
    next_r = r;
    tmv = {chanBTempSenseMv, chanATempSenseMv};
    tick = (r.us == US_LAST);
    next_r.us = tick ? 7'h00 : r.us + 7'h01;
    wr = psel & penable & r.rdy & pwrite;
    goal = 23'h000000;
    rt = 16'h0000;
    chB = 1'b0;
    phEn = 1'b0;

    // Quantised ramp rates
    next_r.rq = {nearRate(r.rate[31:16]), nearRate(r.rate[15:0])};

    // Voltage reset and sync pass two flops first
    next_r.s1 = sharedPinIn;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.vr = (r.ctrl[1:0] == FN_RST) & ~r.s2;

    // Shared pin enables B by default
    en[0] = chanAEnableIn;
    en[1] = (r.ctrl[1:0] == FN_ENB) ? chanBEnableIn : chanAEnableIn;

    for (int c = 0; c < 2; c++) begin
      // Stage line decode
      next_r.uv[c] = tmv[c] < UVLO_MV;
      next_r.sf[c] = tmv[c] >= FAULT_MV;
      if (tmv[c] >= UVLO_MV && tmv[c] < FAULT_MV)
        next_r.temp[c] = 8'((tmv[c] - TEMP_OFS_MV) >>> TEMP_SHIFT);

      // Only non-ignored faults act; warnings never reach here
      raw[c] = {r.sf[c], (c == 0) ? faultEvtA : faultEvtB};
      shut[c] = |(raw[c] & ~r.ign);
      // Critical classes, optional overcurrent and overtemp
      crit[c] = raw[c] & ~r.ign &
                {1'b1, r.ctrl[CTL_OT], r.ctrl[CTL_OC], 4'hF};
      // Latches clear with enable low; a new event wins
      next_r.fl[c] = (r.fl[c] & en[c]) | shut[c];
      next_r.cl[c] = (r.cl[c] & en[c]) | (|crit[c]);

      case (r.cs[c])
        CH_OFF: begin
          next_r.refV[c] = 23'h000000;
          if (en[c] && !shut[c] && !r.fl[c]) begin
            next_r.cs[c] = CH_WAIT;
            // Wait then turn-on delay
            next_r.dly[c] = 17'(WAIT_US) + 17'(r.trans[31:16]);
            next_r.vout[c] = r.boot[c];
          end
        end
        CH_WAIT: begin
          if (!en[c] || shut[c])
            next_r.cs[c] = CH_OFF;
          else if (tick) begin
            // Stages in lockout cannot take PWM yet
            if (r.dly[c] == 17'h00000 && !r.uv[c])
              next_r.cs[c] = CH_RAMP;
            else if (r.dly[c] != 17'h00000)
              next_r.dly[c] = r.dly[c] - 17'h00001;
          end
        end
        CH_RAMP, CH_REG: begin
          if (r.cs[c] == CH_RAMP) begin
            goal = r.boot[c];
            rt = r.rq[15:0];
          end else begin
            // Voltage reset retargets boot
            goal = r.vr ? r.boot[c] : r.vout[c];
            rt = r.trans[15:0];
          end
          if (tick)
            next_r.refV[c] = stepRef(r.refV[c], goal, rt);
          if (r.cs[c] == CH_RAMP && r.refV[c] == r.boot[c])
            next_r.cs[c] = CH_REG;
          if (shut[c] || r.fl[c])
            next_r.cs[c] = CH_OFF;
          else if (!en[c])
            next_r.cs[c] = r.ctrl[CTL_IMMOFF] ? CH_OFF : CH_SOFT;
        end
        CH_SOFT: begin
          if (tick)
            next_r.refV[c] = stepRef(r.refV[c], 23'h000000, r.rq[31:16]);
          if (shut[c] || r.refV[c] == 23'h000000)
            next_r.cs[c] = CH_OFF;
        end
        default: next_r.cs[c] = CH_OFF;
      endcase

      // Good only while regulating past boot
      next_r.pgOe[c] = (next_r.cs[c] != CH_REG);
      conv[c] = (next_r.cs[c] == CH_RAMP) || (next_r.cs[c] == CH_REG) ||
                (next_r.cs[c] == CH_SOFT);
      // Hard stop on faults and immediate-off
      kill[c] = next_r.fl[c] | (r.ctrl[CTL_IMMOFF] & ~conv[c]);
    end

    // Target registers drop writes under voltage reset
    if (wr && paddr == OFS_VOUTA && !r.vr)
      next_r.vout[0] = pwdata[22:0];
    if (wr && paddr == OFS_VOUTB && !r.vr)
      next_r.vout[1] = pwdata[22:0];

    // Channel A only, or both channels
    next_r.critOe = r.cl[0] | (r.ctrl[CTL_BOTH] & r.cl[1]);

    // Three-state PWM per phase
    for (int i = 0; i < 12; i++) begin
      chB = r.map[i];
      phEn = conv[chB] & phaseActive[i] & ~r.uv[chB];
      if (!r.pon[i]) begin
        // Start from undriven straight to high
        if (phEn && pwmCmd[i]) begin
          next_r.pon[i] = 1'b1;
          next_r.pwm[i] = 1'b1;
        end
      end else if (kill[chB]) begin
        next_r.pon[i] = 1'b0;
        next_r.pwm[i] = 1'b0;
      end else if (!phEn && !r.pwm[i] && !pwmCmd[i]) begin
        // Stop only once already low
        next_r.pon[i] = 1'b0;
      end else
        next_r.pwm[i] = pwmCmd[i];
    end

    // Sync edge tracking and on-time trim
    syncEdge = r.s2 & ~r.s3;
    next_r.shOe = (r.ctrl[1:0] == FN_SYNC) & r.sync[SY_MASTER];
    next_r.shOut = r.pwm[0];
    if (r.ctrl[1:0] != FN_SYNC || !r.sync[SY_EN] || r.sync[SY_MASTER])
      next_r.lock = 1'b0;
    else if (syncEdge) begin
      next_r.dcnt = (r.dcnt == r.sync[SY_DIV+:4]) ? 4'h0 : r.dcnt + 4'h1;
      if (loadTransient)
        next_r.lock = 1'b0;
      else if (r.dcnt == r.sync[SY_DIV+:4]) begin
        // Small trims give the slow relock after transients
        next_r.trim = r.pwm[0] ? r.trim - {4'h0, r.sync[SY_GAIN+:4]}
                               : r.trim + {4'h0, r.sync[SY_GAIN+:4]};
        next_r.dir = r.pwm[0];
        next_r.lock = (r.dir != r.pwm[0]);
      end
    end

    // APB slave: answer one cycle after setup
    next_r.rdy = psel & ~penable;
    next_r.err = 1'b0;
    next_r.rdata = 32'h00000000;
    if (psel && !penable) begin
      case (paddr)
        OFS_CTRL:   next_r.rdata = {26'h0, r.ctrl};
        OFS_STATUS: next_r.rdata = {18'h0, r.fl, criticalFaultNIn,
                                    chanBPowerGoodIn, chanAPowerGoodIn,
                                    r.lock, r.vr, r.sf, r.uv, r.critOe,
                                    ~r.pgOe};
        OFS_IGNORE: next_r.rdata = {25'h0, r.ign};
        OFS_RATE:   next_r.rdata = r.rate;
        OFS_RATEQ:  next_r.rdata = r.rq;
        OFS_TRANS:  next_r.rdata = r.trans;
        OFS_BOOTA:  next_r.rdata = {9'h0, r.boot[0]};
        OFS_BOOTB:  next_r.rdata = {9'h0, r.boot[1]};
        OFS_VOUTA:  next_r.rdata = {9'h0, r.vout[0]};
        OFS_VOUTB:  next_r.rdata = {9'h0, r.vout[1]};
        OFS_SYNC:   next_r.rdata = {14'h0, r.sync};
        OFS_PHMAP:  next_r.rdata = {20'h0, r.map};
        OFS_TEMP:   next_r.rdata = {8'h0, r.temp[1], 8'h0, r.temp[0]};
        OFS_TRIM:   next_r.rdata = {24'h0, r.trim};
        default:    next_r.err = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        OFS_CTRL:   next_r.ctrl = pwdata[5:0];
        OFS_IGNORE: next_r.ign = pwdata[6:0];
        OFS_RATE:   next_r.rate = pwdata;
        OFS_TRANS:  next_r.trans = pwdata;
        OFS_BOOTA:  next_r.boot[0] = pwdata[22:0];
        OFS_BOOTB:  next_r.boot[1] = pwdata[22:0];
        OFS_SYNC:   next_r.sync = pwdata[17:0];
        OFS_PHMAP:  next_r.map = pwdata[11:0];
        default:    next_r.ctrl = r.ctrl;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= '0;
      r.cs <= '{CH_OFF, CH_OFF};
      r.boot <= {BOOT_RST, BOOT_RST};
      r.vout <= {BOOT_RST, BOOT_RST};
      r.trans <= {16'h0000, TRANS_RST};
      r.pgOe <= 2'h3;
      r.s1 <= 1'b1;
      r.s2 <= 1'b1;
      r.s3 <= 1'b1;
    end else
      r <= next_r;
  end

  assign prdata = r.rdata;
  assign pready = r.rdy;
  assign pslverr = r.err;
  assign sharedPinOut = r.shOut;
  assign sharedPinOe = r.shOe;
  assign pwmOut = r.pwm;
  assign pwmOe = r.pon;
  assign chanAPowerGoodOut = 1'b0;
  assign chanBPowerGoodOut = 1'b0;
  assign criticalFaultNOut = 1'b0;
  assign chanAPowerGoodOe = r.pgOe[0];
  assign chanBPowerGoodOe = r.pgOe[1];
  assign criticalFaultNOe = r.critOe;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  property p_pgRelease;
    $fell(chanAPowerGoodOe) |-> r.refV[0] == r.boot[0];
  endproperty
  a_pgRelease: assert property (p_pgRelease)
    else $error("power good released before boot reached");

  property p_pgStop;
    r.cs[0] == CH_REG && !chanAEnableIn |=> chanAPowerGoodOe;
  endproperty
  a_pgStop: assert property (p_pgStop)
    else $error("power good held after disable");

  property p_critCause;
    $rose(criticalFaultNOe) |-> $past(r.cl[0] | r.cl[1], 1);
  endproperty
  a_critCause: assert property (p_critCause)
    else $error("fault output without critical fault");

  property p_voutDrop;
    r.vr && wr && paddr == OFS_VOUTA |=> $stable(r.vout[0]);
  endproperty
  a_voutDrop: assert property (p_voutDrop)
    else $error("target accepted during voltage reset");

  property p_startHigh;
    $rose(pwmOe[0]) |-> pwmOut[0];
  endproperty
  a_startHigh: assert property (p_startHigh)
    else $error("phase started not high");

  property p_stopLow;
    $fell(pwmOe[0]) && !$past(kill[r.map[0]]) |-> $past(!pwmOut[0]);
  endproperty
  a_stopLow: assert property (p_stopLow)
    else $error("phase stopped from high");

  property p_immOff;
    r.ctrl[CTL_IMMOFF] && r.cs[0] == CH_REG && !chanAEnableIn &&
    !r.map[0] ##1 1'b1 |=> !pwmOe[0];
  endproperty
  a_immOff: assert property (p_immOff)
    else $error("phase driven after immediate off");

  property p_waitDone;
    $rose(r.cs[0] == CH_RAMP) |-> $past(r.dly[0]) == 17'h00000;
  endproperty
  a_waitDone: assert property (p_waitDone)
    else $error("ramp began before start delay");

  property p_tempCalc;
    chanATempSenseMv == 12'h3E8 |=> r.temp[0] == 8'h32;
  endproperty
  a_tempCalc: assert property (p_tempCalc)
    else $error("temperature conversion wrong");

  c_ramp: cover property ($rose(r.cs[0] == CH_REG));
  c_vreset: cover property (r.vr && r.cs[1] == CH_REG);
  c_lock: cover property ($rose(r.lock));
  c_fault: cover property ($rose(criticalFaultNOe));
endmodule
`default_nettype wire

//--- test/rpsp_stage_model.sv
// Power stage and host pin model around the regulator block
`default_nettype none
module rpsp_stage_model (
  // Stage conditions per channel
  input  wire logic [1:0]  stageUvlo,
  input  wire logic [1:0]  stageFault,
  input  wire logic [11:0] tempMvA,
  input  wire logic [11:0] tempMvB,
  output var  logic [11:0] senseMvA,
  output var  logic [11:0] senseMvB,
  // Open-drain pins with pull-ups
  input  wire logic        pgAOe,
  input  wire logic        pgBOe,
  input  wire logic        critOe,
  output var  logic        pgA,
  output var  logic        pgB,
  output var  logic        critN,
  // Shared pin, follows voltResetN when the block does not drive it
  input  wire logic        voltResetN,
  input  wire logic        sharedOe,
  input  wire logic        sharedOut,
  output var  logic        sharedPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stage in lockout pulls the line low, internal fault pulls it high
  assign senseMvA = stageUvlo[0] ? 12'h000 :
                    stageFault[0] ? 12'hC80 : tempMvA;
  assign senseMvB = stageUvlo[1] ? 12'h000 :
                    stageFault[1] ? 12'hC80 : tempMvB;
  // Pull-up wins whenever nobody pulls low
  assign pgA = !pgAOe;
  assign pgB = !pgBOe;
  assign critN = !critOe;
  assign sharedPin = sharedOe ? sharedOut : voltResetN;
endmodule
`default_nettype wire

//--- test/test_regulator_pin_status_sync_phase.sv
// Self-checking bench of the regulator pin, status and sync block
`default_nettype none
module test_regulator_pin_status_sync_phase;
  timeunit 1ns;
  timeprecision 1ps;
  import rpsp_pkg::*;
  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, pins;
  logic [31:0] pwdata, prdata;
  logic        chanAEnableIn, chanBEnableIn, sharedPin, sharedPinOut;
  logic        sharedPinOe, loadTransient, voltResetN;
  logic [5:0]  faultEvtA, faultEvtB;
  logic [11:0] senseA, senseB, tempA, tempB, phaseActive, pwmCmd;
  logic [11:0] pwmOut, pwmOe;
  logic [1:0]  uvlo, sfault;
  logic        pgA, pgB, critN, pgAOe, pgBOe, critOe;
  logic [64:0] note;
  logic [64:0] expq[$];
  int          failures, n_checks, cyc;

  rpsp_core #(.STARTUP_WAIT_US(5)) u_dut (.core_clk(core_clk),
    .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chanAEnableIn(chanAEnableIn),
    .chanBEnableIn(chanBEnableIn), .sharedPinIn(sharedPin),
    .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe),
    .faultEvtA(faultEvtA), .faultEvtB(faultEvtB),
    .loadTransient(loadTransient), .chanATempSenseMv(senseA),
    .chanBTempSenseMv(senseB), .phaseActive(phaseActive), .pwmCmd(pwmCmd),
    .pwmOut(pwmOut), .pwmOe(pwmOe), .chanAPowerGoodIn(pgA),
    .chanAPowerGoodOut(), .chanAPowerGoodOe(pgAOe), .chanBPowerGoodIn(pgB),
    .chanBPowerGoodOut(), .chanBPowerGoodOe(pgBOe), .criticalFaultNIn(critN),
    .criticalFaultNOut(), .criticalFaultNOe(critOe));

  rpsp_stage_model u_stage (.stageUvlo(uvlo), .stageFault(sfault),
    .tempMvA(tempA), .tempMvB(tempB), .senseMvA(senseA), .senseMvB(senseB),
    .pgAOe(pgAOe), .pgBOe(pgBOe), .critOe(critOe), .pgA(pgA), .pgB(pgB),
    .critN(critN), .voltResetN(voltResetN), .sharedOe(sharedPinOe),
    .sharedOut(sharedPinOut), .sharedPin(sharedPin));

  // Pins watched by index: 0 good A, 1 good B, 2 fault, 3 drive ph0,
  // 4 level ph0, 5 drive ph1, 6 drive ph6, 7 any channel A drive
  assign pins = {|pwmOe[5:0], pwmOe[6], pwmOe[1], pwmOut[0], pwmOe[0],
                 critOe, pgBOe, pgAOe};

  task automatic results();
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Bounded wait for a pin, sampled at the falling edge where it is settled
  task automatic pin(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (pins[i] !== v && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    n_checks++;
    if (pins[i] !== v) begin
      failures++;
      $display("ERROR %0t pin %0d is %b", $time, i, pins[i]);
    end
  endtask

  // One APB transfer; a read leaves its expected word for the watcher
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] m = 32'hFFFFFFFF,
                     input logic e = 1'b0);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    if (!w) expq.push_back({e, m, d});
    @(posedge core_clk);
    penable <= 1'b1;
    @(negedge core_clk);
    while (pready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Watcher: oldest note against each completed read; also the hang limit
  always @(posedge core_clk) begin
    cyc++;
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      note = expq.pop_front();
      n_checks++;
      if ((prdata & note[63:32]) !== note[31:0] || pslverr !== note[64]) begin
        failures++;
        $display("ERROR %0t read %h at %h", $time, prdata, paddr);
      end
    end
    if (cyc == 40000) begin
      failures++;
      results();
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {chanAEnableIn, chanBEnableIn, loadTransient, voltResetN} = 4'h1;
    {faultEvtA, faultEvtB, uvlo, sfault, phaseActive, pwmCmd} = 40'h0;
    tempA = 12'h3E8;
    tempB = 12'(32'h258 + $urandom(32'h45FD) % 32'h76C);
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    apb(OFS_TRANS, 1'b0, 32'h000003E8, 32'h0000FFFF);
    apb(OFS_BOOTA, 1'b0, 32'h000F4240);
    apb(8'h3C, 1'b0, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(OFS_BOOTA, 1'b1, 32'h00002710);
    apb(OFS_RATE, 1'b1, 32'h791892E0);
    apb(OFS_PHMAP, 1'b1, 32'h00000FC0);
    apb(OFS_CTRL, 1'b1, 32'h00000004);
    phaseActive <= 12'hFFF;
    pwmCmd <= 12'hFFF;
    chanAEnableIn <= 1'b1;
    pin(0, 1'b0, 3000);
    pin(1, 1'b1, 0);
    pin(3, 1'b1, 0);
    pin(4, 1'b1, 0);
    apb(OFS_RATEQ, 1'b0, 32'h75309C40);
    apb(OFS_TEMP, 1'b0, {8'h0, 8'((tempB - 12'h258) >> 3), 16'h0032},
        32'h00FF00FF);
    pwmCmd[1] <= 1'b0;
    phaseActive[1] <= 1'b0;
    pin(5, 1'b0, 20);
    apb(OFS_IGNORE, 1'b1, 32'h00000040);
    sfault <= 2'b01;
    repeat (50) @(negedge core_clk);
    pin(2, 1'b0, 0);
    pin(0, 1'b0, 0);
    @(posedge core_clk);
    sfault <= 2'b00;
    apb(OFS_IGNORE, 1'b1, 32'h0);
    // Shared pin as voltage reset: enable A now starts both channels
    apb(OFS_CTRL, 1'b1, 32'h00000005);
    voltResetN <= 1'b0;
    pin(6, 1'b1, 2000);
    apb(OFS_STATUS, 1'b0, 32'h80, 32'h80);
    apb(OFS_VOUTA, 1'b1, 32'h00004E20);
    apb(OFS_VOUTA, 1'b0, 32'h00002710);
    pin(0, 1'b0, 0);
    voltResetN <= 1'b1;
    chanAEnableIn <= 1'b0;
    pin(7, 1'b0, 3);
    pin(0, 1'b1, 3);
    pin(1, 1'b1, 3);
    @(posedge core_clk);
    chanAEnableIn <= 1'b1;
    pin(0, 1'b0, 3000);
    @(posedge core_clk);
    sfault <= 2'b01;
    pin(2, 1'b1, 20);
    pin(0, 1'b1, 20);
    pin(7, 1'b0, 5);
    apb(OFS_STATUS, 1'b0, 32'h20, 32'h20);
    // Stages in lockout hold the channel before its ramp
    sfault <= 2'b00;
    uvlo <= 2'b01;
    chanAEnableIn <= 1'b0;
    repeat (3) @(posedge core_clk);
    chanAEnableIn <= 1'b1;
    repeat (1500) @(negedge core_clk);
    pin(0, 1'b1, 0);
    pin(3, 1'b0, 0);
    apb(OFS_STATUS, 1'b0, 32'h08, 32'h08);
    // Shared pin as sync slave, gain 1; phase 0 idle low so trim climbs
    apb(OFS_CTRL, 1'b1, 32'h00000006);
    apb(OFS_SYNC, 1'b1, 32'h00004001);
    repeat (4) begin
      voltResetN <= 1'b0;
      repeat (5) @(posedge core_clk);
      voltResetN <= 1'b1;
      repeat (5) @(posedge core_clk);
    end
    apb(OFS_TRIM, 1'b0, 32'h04, 32'hFF);
    apb(OFS_SYNC, 1'b1, 32'h0);
    apb(OFS_SYNC, 1'b0, 32'h0);
    results();
  end
endmodule
`default_nettype wire
